/* File: rtl/tgo_pkg.sv */
// constants, field codes and carrier structs for the timer gate and overflow control block
// assumes one clock; the selected timer clock arrives as a one-cycle tick on that clock
//
// Contract
// - gate source code 00 pin, 01 timer0 wrap, 10 comparator one, 11 comparator two.
// - one polarity setting applies to whichever gate source is selected.
// - eight-bit timer wrap FFh to 00h makes a rising pulse into the gate.
// - comparator source passes re-timed to the timer clock or raw, per option.
// - toggle mode flips a flip-flop on each incrementing gate edge; full period counts.
// - toggle flip-flop forced and held at zero while toggle mode is off.
// - single-pulse: enable, then arm; counting starts at next incrementing gate edge.
// - trailing edge of captured pulse clears arm; further gate events ignored until rearmed.
// - toggle plus single-pulse counts exactly one full gate cycle per arming.
// - gate level status readable, valid even with gate counting disabled.
// - falling edge of gate level status sets gate event flag; irq when enabled.
// - gate event flag keeps being set while gate counting is disabled.
// - counter increments to FFFFh, rolls to 0000h and sets overflow flag.
// - overflow interrupt needs timer on, overflow, peripheral and global enables.
// - sleep counting only in async external mode; overflow wakes when enabled.
// - after wake resume next instruction, or enter service routine if global enable.
// - low-power oscillator keeps running in sleep regardless of sync bit.
// - capture copies counter on event; compare signals when pair equals counter.
// - special event clears counter without overflow flag; software write wins.
// - off without timer on; always counts without gate enable; else gated.
// - gated counting increments on tick only when gate level equals polarity.
package tgo_pkg;

  localparam logic [1:0] GSS_PIN = 2'h0;
  localparam logic [1:0] GSS_T0_WRAP = 2'h1;
  localparam logic [1:0] GSS_CMP_ONE = 2'h2;
  localparam logic [1:0] GSS_CMP_TWO = 2'h3;

  localparam logic [1:0] CS_EXTERNAL = 2'h2;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] T0_MAX = 8'hFF;
  localparam logic [7:0] T0_ZERO = 8'h00;

  typedef struct packed {
    logic timer_on;
    logic gate_count_enable;
    logic gate_polarity;
    logic gate_toggle_enable;
    logic gate_single_pulse_enable;
    logic [1:0] gate_source_select;
    logic cmp_one_sync;
    logic cmp_two_sync;
    logic ext_clock_sync_n;
    logic [1:0] clock_source_select;
    logic low_power_osc_enable;
  } tgo_cfg_s;

  typedef struct packed {
    logic overflow_irq_enable;
    logic gate_event_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
  } tgo_irq_en_s;

  typedef struct packed {
    logic overflow_irq;
    logic gate_event_irq;
    logic wake;
    logic wake_to_isr;
  } tgo_irq_out_s;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capture_compare_pair;
    logic compare_match;
    logic overflow_flag;
    logic gate_level_status;
    logic gate_event_flag;
    logic gate_pulse_arm;
    logic toggle_ff;
    logic pulse_run;
    logic active_prev;
    logic gated_prev;
    logic [7:0] t0_prev;
    logic t0_wrap;
    tgo_irq_out_s irq;
    logic osc_run;
  } tgo_state_s;

  localparam tgo_state_s STATE_RESET = '0;

  typedef struct packed {
    logic retimed;
  } tgo_rt_state_s;

endpackage

/* File: rtl/tgo_retime.sv */
// re-times one comparator output onto the selected timer clock tick
// assumes the tick is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module tgo_retime (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_level,
  output logic o_level
);
  tgo_pkg::tgo_rt_state_s r;
  tgo_pkg::tgo_rt_state_s next_r;

  always_comb begin
    next_r = r;
    if (i_tick) begin
      next_r.retimed = i_level;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.retimed;
endmodule
`default_nettype wire

/* File: rtl/tgo_timer.sv */
// gate selection, gate modes, 16-bit counter, overflow, sleep wake and ccp time base
// assumes all inputs synchronous to I_CLOCK; I_TIMER_TICK marks each selected timer clock edge
`timescale 1ns/1ps
`default_nettype none
module tgo_timer (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire tgo_pkg::tgo_cfg_s I_CFG,
  input wire tgo_pkg::tgo_irq_en_s I_IRQ_EN,
  input wire logic I_TIMER_TICK,
  input wire logic I_SLEEP,
  input wire logic I_GATE_INPUT_PIN,
  input wire logic [7:0] I_EIGHT_BIT_TIMER_COUNT,
  input wire logic I_COMPARATOR_ONE_OUTPUT,
  input wire logic I_COMPARATOR_TWO_OUTPUT,
  input wire logic I_GATE_PULSE_ARM_SET,
  input wire logic I_GATE_PULSE_ARM_CLR,
  input wire logic I_GATE_EVENT_FLAG_CLR,
  input wire logic I_OVERFLOW_FLAG_CLR,
  input wire logic I_COUNT_WR,
  input wire logic [15:0] I_COUNT_WDATA,
  input wire logic I_CAPTURE_EVENT,
  input wire logic I_SPECIAL_EVENT,
  input wire logic [15:0] I_COMPARE_PAIR,
  output logic [15:0] O_COUNTER_PAIR,
  output logic [15:0] O_CAPTURE_COMPARE_PAIR,
  output logic O_COMPARE_MATCH,
  output logic O_OVERFLOW_FLAG,
  output logic O_GATE_LEVEL_STATUS,
  output logic O_GATE_EVENT_FLAG,
  output logic O_GATE_PULSE_ARM,
  output tgo_pkg::tgo_irq_out_s O_IRQ,
  output logic O_OSC_RUN
);
  tgo_pkg::tgo_state_s r;
  tgo_pkg::tgo_state_s next_r;

  logic cmp_one_rt;
  logic cmp_two_rt;

  tgo_retime u_rt_one (
    .i_clock(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_tick(I_TIMER_TICK),
    .i_level(I_COMPARATOR_ONE_OUTPUT),
    .o_level(cmp_one_rt)
  );

  tgo_retime u_rt_two (
    .i_clock(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_tick(I_TIMER_TICK),
    .i_level(I_COMPARATOR_TWO_OUTPUT),
    .o_level(cmp_two_rt)
  );

  logic src;
  logic active;
  logic active_rise;
  logic toggled;
  logic gated;
  logic gated_rise;
  logic gated_fall;
  logic gate_val;
  logic sleep_ok;
  logic count_en;
  logic rollover;
  logic wake_ok;

  // gate source and polarity
  always_comb begin
    case (I_CFG.gate_source_select)
      tgo_pkg::GSS_PIN: src = I_GATE_INPUT_PIN;
      tgo_pkg::GSS_T0_WRAP: src = r.t0_wrap;
      tgo_pkg::GSS_CMP_ONE: src = I_CFG.cmp_one_sync ? cmp_one_rt : I_COMPARATOR_ONE_OUTPUT;
      tgo_pkg::GSS_CMP_TWO: src = I_CFG.cmp_two_sync ? cmp_two_rt : I_COMPARATOR_TWO_OUTPUT;
      default: src = 1'b0;
    endcase
  end

  // active means the gate permits counting; polarity folds in here for every source
  assign active = I_CFG.gate_polarity ? src : ~src;
  assign active_rise = active & ~r.active_prev;

  // toggle stage: sees the flip-flop output only when enabled
  assign toggled = I_CFG.gate_toggle_enable ? r.toggle_ff : active;

  // edges of the toggle stage output feed the single-pulse stage
  assign gated_rise = toggled & ~r.gated_prev;
  assign gated_fall = ~toggled & r.gated_prev;

  // single-pulse stage: a captured pulse runs from the rise after arming to its fall
  assign gated = I_CFG.gate_single_pulse_enable ? (toggled & (r.pulse_run | (gated_rise
    & r.gate_pulse_arm))) : toggled;
  assign gate_val = gated;

  // sleep only keeps counting in asynchronous external mode
  assign sleep_ok = ~I_SLEEP | (I_CFG.ext_clock_sync_n
    & (I_CFG.clock_source_select == tgo_pkg::CS_EXTERNAL));

  assign count_en = I_CFG.timer_on & (~I_CFG.gate_count_enable | gate_val) & sleep_ok;
  // a write or special event on the wrap cycle is no rollover, so neither flag nor wake fires
  assign rollover = count_en & I_TIMER_TICK & (r.count == tgo_pkg::CNT_MAX)
    & ~I_COUNT_WR & ~I_SPECIAL_EVENT;

  assign wake_ok = I_CFG.timer_on & I_IRQ_EN.overflow_irq_enable
    & I_IRQ_EN.peripheral_irq_enable & I_CFG.ext_clock_sync_n;

  always_comb begin
    next_r = r;

    // eight-bit timer wrap becomes a one-cycle rising pulse
    next_r.t0_prev = I_EIGHT_BIT_TIMER_COUNT;
    next_r.t0_wrap = (r.t0_prev == tgo_pkg::T0_MAX)
      & (I_EIGHT_BIT_TIMER_COUNT == tgo_pkg::T0_ZERO);

    next_r.active_prev = active;
    next_r.gated_prev = toggled;

    // toggle flip-flop held clear while the mode is off, so the measured edge is known
    if (!I_CFG.gate_toggle_enable) begin
      next_r.toggle_ff = 1'b0;
    end else if (active_rise) begin
      next_r.toggle_ff = ~r.toggle_ff;
    end

    // single pulse capture and automatic disarm on the trailing edge
    if (!I_CFG.gate_single_pulse_enable) begin
      next_r.pulse_run = 1'b0;
    end else if (gated_rise && r.gate_pulse_arm) begin
      next_r.pulse_run = 1'b1;
    end else if (gated_fall && r.pulse_run) begin
      next_r.pulse_run = 1'b0;
    end

    // a software arm in the same cycle as the hardware disarm wins
    if (I_GATE_PULSE_ARM_SET) begin
      next_r.gate_pulse_arm = 1'b1;
    end else if (I_GATE_PULSE_ARM_CLR) begin
      next_r.gate_pulse_arm = 1'b0;
    end else if (I_CFG.gate_single_pulse_enable && gated_fall && r.pulse_run) begin
      next_r.gate_pulse_arm = 1'b0;
    end

    // level status does not depend on gate counting being enabled
    next_r.gate_level_status = gate_val;

    // gate event on falling edge of the status; set wins over a software clear
    if (r.gate_level_status && !gate_val) begin
      next_r.gate_event_flag = 1'b1;
    end else if (I_GATE_EVENT_FLAG_CLR) begin
      next_r.gate_event_flag = 1'b0;
    end

    // counter: software write beats the special event, which beats counting
    if (I_COUNT_WR) begin
      next_r.count = I_COUNT_WDATA;
    end else if (I_SPECIAL_EVENT) begin
      next_r.count = tgo_pkg::CNT_ZERO;
    end else if (count_en && I_TIMER_TICK) begin
      next_r.count = r.count + tgo_pkg::CNT_ONE;
    end

    // special event and software write suppress the rollover flag
    if (rollover && !I_COUNT_WR && !I_SPECIAL_EVENT) begin
      next_r.overflow_flag = 1'b1;
    end else if (I_OVERFLOW_FLAG_CLR) begin
      next_r.overflow_flag = 1'b0;
    end

    // time base for capture and compare
    if (I_CAPTURE_EVENT) begin
      next_r.capture_compare_pair = r.count;
    end
    next_r.compare_match = (r.count == I_COMPARE_PAIR);

    next_r.irq.overflow_irq = next_r.overflow_flag & I_CFG.timer_on
      & I_IRQ_EN.overflow_irq_enable & I_IRQ_EN.peripheral_irq_enable
      & I_IRQ_EN.global_irq_enable;
    next_r.irq.gate_event_irq = next_r.gate_event_flag & I_IRQ_EN.gate_event_irq_enable;

    // wake is a one-cycle pulse; the isr line says where execution resumes
    next_r.irq.wake = I_SLEEP & rollover & wake_ok;
    next_r.irq.wake_to_isr = I_SLEEP & rollover & wake_ok & I_IRQ_EN.global_irq_enable;

    // oscillator enable is independent of sleep and of the sync bit
    next_r.osc_run = I_CFG.low_power_osc_enable;
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      r <= tgo_pkg::STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign O_COUNTER_PAIR = r.count;
  assign O_CAPTURE_COMPARE_PAIR = r.capture_compare_pair;
  assign O_COMPARE_MATCH = r.compare_match;
  assign O_OVERFLOW_FLAG = r.overflow_flag;
  assign O_GATE_LEVEL_STATUS = r.gate_level_status;
  assign O_GATE_EVENT_FLAG = r.gate_event_flag;
  assign O_GATE_PULSE_ARM = r.gate_pulse_arm;
  assign O_IRQ = r.irq;
  assign O_OSC_RUN = r.osc_run;
endmodule
`default_nettype wire

/* File: bench/tgo_props.sv */
// port checks for tgo_timer
// bound onto every tgo_timer instance; one clock domain
`timescale 1ns/1ps
`default_nettype none
module tgo_props (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire tgo_pkg::tgo_cfg_s I_CFG,
  input wire tgo_pkg::tgo_irq_en_s I_IRQ_EN,
  input wire logic I_TIMER_TICK,
  input wire logic I_SLEEP,
  input wire logic I_COUNT_WR,
  input wire logic [15:0] I_COUNT_WDATA,
  input wire logic I_CAPTURE_EVENT,
  input wire logic I_SPECIAL_EVENT,
  input wire logic [15:0] O_COUNTER_PAIR,
  input wire logic [15:0] O_CAPTURE_COMPARE_PAIR,
  input wire logic O_OVERFLOW_FLAG,
  input wire logic O_GATE_LEVEL_STATUS,
  input wire logic O_GATE_EVENT_FLAG,
  input wire tgo_pkg::tgo_irq_out_s O_IRQ,
  input wire logic O_OSC_RUN
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);
  a_roll_over: assert property (
    O_COUNTER_PAIR == 16'hFFFF && I_TIMER_TICK && I_CFG.timer_on && !I_SLEEP
    && !I_CFG.gate_count_enable && !I_COUNT_WR && !I_SPECIAL_EVENT
    |=> O_COUNTER_PAIR == 16'h0000 && O_OVERFLOW_FLAG) else $error("no wrap");
  a_irq_enables: assert property (
    O_IRQ.overflow_irq |-> $past(I_CFG.timer_on && I_IRQ_EN.overflow_irq_enable
    && I_IRQ_EN.peripheral_irq_enable && I_IRQ_EN.global_irq_enable)) else $error("bad irq");
  a_write_wins: assert property (
    I_COUNT_WR |=> O_COUNTER_PAIR == $past(I_COUNT_WDATA)) else $error("bad write");
  a_special_clear: assert property (
    I_SPECIAL_EVENT && !I_COUNT_WR && !O_OVERFLOW_FLAG
    |=> O_COUNTER_PAIR == 16'h0000 && !O_OVERFLOW_FLAG) else $error("bad clear");
  a_capture_copy: assert property (
    I_CAPTURE_EVENT |=> O_CAPTURE_COMPARE_PAIR == $past(O_COUNTER_PAIR))
    else $error("bad capture");
  a_off_hold: assert property (
    !I_CFG.timer_on && !I_COUNT_WR && !I_SPECIAL_EVENT |=> $stable(O_COUNTER_PAIR))
    else $error("count moved");
  a_gate_event: assert property (
    $fell(O_GATE_LEVEL_STATUS) |-> ##[0:1] O_GATE_EVENT_FLAG) else $error("no event");
  a_wake_pulse: assert property (
    O_IRQ.wake |-> O_OVERFLOW_FLAG ##1 !O_IRQ.wake) else $error("bad wake");
  a_wake_isr: assert property (
    O_IRQ.wake_to_isr |-> O_IRQ.wake) else $error("bad isr");
  a_osc_follow: assert property (
    1 |=> O_OSC_RUN == $past(I_CFG.low_power_osc_enable)) else $error("bad osc");
endmodule
bind tgo_timer tgo_props u_props (.I_CLOCK, .I_SYS_RST, .I_CFG, .I_IRQ_EN, .I_TIMER_TICK,
  .I_SLEEP, .I_COUNT_WR, .I_COUNT_WDATA, .I_CAPTURE_EVENT, .I_SPECIAL_EVENT,
  .O_COUNTER_PAIR, .O_CAPTURE_COMPARE_PAIR, .O_OVERFLOW_FLAG, .O_GATE_LEVEL_STATUS,
  .O_GATE_EVENT_FLAG, .O_IRQ, .O_OSC_RUN);
`default_nettype wire

/* File: bench/tgo_t0_model.sv */
// eight-bit timer feeding the gate's wrap source
// same clock as the block; counts only while i_run is high
`timescale 1ns/1ps
`default_nettype none
module tgo_t0_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  output logic [7:0] o_count
);
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_count <= 8'h00;
    else if (i_run) o_count <= o_count + 8'h01;
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for tgo_timer
// tgo_t0_model beside the block, tgo_props bound onto it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tgo_pkg::tgo_cfg_s c = '0;
  tgo_pkg::tgo_irq_en_s e = '0;
  logic tick = 1'b0, slp = 1'b0, pin = 1'b0, c1 = 1'b0, c2 = 1'b0, run = 1'b0;
  logic as = 1'b0, ac = 1'b0, gc = 1'b0, oc = 1'b0, wr = 1'b0, cap = 1'b0, sev = 1'b0;
  logic [15:0] wd = 16'h0000, cp = 16'h0000, cnt, ccp;
  logic [7:0] t0;
  logic mt, of, gl, gf, arm, osc, lv;
  tgo_pkg::tgo_irq_out_s irq;
  int fails = 0, compares = 0, i;
  logic [15:0] exp_q[$];
  logic [3:0] sel_q[$];
  always #2.5 clk = ~clk;
  tgo_t0_model u_t0 (.i_clock(clk), .i_rst(rst), .i_run(run), .o_count(t0));
  tgo_timer u_dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_CFG(c), .I_IRQ_EN(e), .I_TIMER_TICK(tick),
    .I_SLEEP(slp), .I_GATE_INPUT_PIN(pin), .I_EIGHT_BIT_TIMER_COUNT(t0),
    .I_COMPARATOR_ONE_OUTPUT(c1), .I_COMPARATOR_TWO_OUTPUT(c2), .I_GATE_PULSE_ARM_SET(as),
    .I_GATE_PULSE_ARM_CLR(ac), .I_GATE_EVENT_FLAG_CLR(gc), .I_OVERFLOW_FLAG_CLR(oc),
    .I_COUNT_WR(wr), .I_COUNT_WDATA(wd), .I_CAPTURE_EVENT(cap), .I_SPECIAL_EVENT(sev),
    .I_COMPARE_PAIR(cp), .O_COUNTER_PAIR(cnt), .O_CAPTURE_COMPARE_PAIR(ccp),
    .O_COMPARE_MATCH(mt), .O_OVERFLOW_FLAG(of), .O_GATE_LEVEL_STATUS(gl),
    .O_GATE_EVENT_FLAG(gf), .O_GATE_PULSE_ARM(arm), .O_IRQ(irq), .O_OSC_RUN(osc));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // mask order: on, gate enable, polarity, toggle, single pulse
  task automatic cf(input logic [4:0] m, input logic [1:0] s);
    c = {m, s, 6'h00};
  endtask
  // the watcher reads outputs 1 ns after the falling edge on which the note is called, before the note's own wait ends, well away from any update
  task automatic note(input logic [3:0] s, input logic [15:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
    @(negedge clk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clk) begin
    #1;
    if (sel_q.size() > 0) begin
      case (sel_q[0])
        4'h0: check(cnt, exp_q[0]);
        4'h1: check(ccp, exp_q[0]);
        4'h2: check({15'h0000, mt}, exp_q[0]);
        4'h3: check({15'h0000, of}, exp_q[0]);
        4'h4: check({15'h0000, gl}, exp_q[0]);
        4'h5: check({15'h0000, gf}, exp_q[0]);
        4'h6: check({15'h0000, arm}, exp_q[0]);
        4'h7: check({12'h000, irq}, exp_q[0]);
        default: check({15'h0000, osc}, exp_q[0]);
      endcase
      void'(sel_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  initial begin
    #20000;
    fails++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h36CD));
    cyc(10);
    rst = 1'b0;
    cyc(1);
    note(4'h0, 16'h0000);
    cf(5'h10, 2'h0);
    wd = 16'hFFFE;
    pulse(wr);
    pulse(oc);
    e = 4'hB;
    tick = 1'b1;
    cyc(2);
    tick = 1'b0;
    note(4'h0, 16'h0000);
    note(4'h3, 16'h0001);
    note(4'h7, 16'h0008);
    e = 4'hA;
    cyc(1);
    note(4'h7, 16'h0000);
    pulse(oc);
    wd = 16'h1234;
    wr = 1'b1;
    sev = 1'b1;
    cyc(1);
    wr = 1'b0;
    sev = 1'b0;
    note(4'h0, 16'h1234);
    pulse(sev);
    note(4'h0, 16'h0000);
    note(4'h3, 16'h0000);
    wd = 16'($urandom);
    pulse(wr);
    cp = wd;
    pulse(cap);
    note(4'h1, wd);
    note(4'h2, 16'h0001);
    for (i = 0; i < 8; i++) begin
      if (i[2:1] == 2'h1) continue;
      lv = 1'($urandom);
      cf({2'b11, i[0], 2'b00}, i[2:1]);
      pin = (i[2:1] == 2'h0) ? lv : ~lv;
      c1 = (i[2:1] == 2'h2) ? lv : ~lv;
      c2 = (i[2:1] == 2'h3) ? lv : ~lv;
      wd = 16'h0000;
      pulse(wr);
      cyc(2);
      pulse(tick);
      cyc(2);
      note(4'h0, {15'h0000, lv == i[0]});
      cf({2'b10, i[0], 2'b00}, i[2:1]);
      cyc(1);
      note(4'h4, {15'h0000, lv == i[0]});
      pulse(gc);
      pin = ~pin;
      c1 = ~c1;
      c2 = ~c2;
      cyc(3);
      note(4'h5, {15'h0000, lv == i[0]});
    end
    // retimed comparator: the gate only sees a new comparator level after a tick
    cf(5'h14, 2'h2);
    c.cmp_one_sync = 1'b1;
    c1 = 1'b0;
    pulse(tick);
    c1 = 1'b1;
    cyc(2);
    note(4'h4, 16'h0000);
    pulse(tick);
    cyc(1);
    note(4'h4, 16'h0001);
    cf(5'h1C, 2'h1);
    wd = 16'h0000;
    pulse(wr);
    tick = 1'b1;
    run = 1'b1;
    cyc(300);
    run = 1'b0;
    tick = 1'b0;
    cyc(2);
    note(4'h0, 16'h0001);
    pin = 1'b0;
    // polarity already high, so toggle is not switched with a polarity change
    cf(5'h1F, 2'h0);
    pulse(wr);
    pulse(as);
    note(4'h6, 16'h0001);
    tick = 1'b1;
    for (i = 0; i < 4; i++) begin
      pin = 1'b1;
      cyc(6);
      pin = 1'b0;
      cyc(6);
    end
    tick = 1'b0;
    cyc(2);
    note(4'h0, 16'h000C);
    note(4'h6, 16'h0000);
    cf(5'h1C, 2'h0);
    pulse(ac);
    cf(5'h10, 2'h0);
    c.ext_clock_sync_n = 1'b1;
    c.clock_source_select = 2'h2;
    c.low_power_osc_enable = 1'b1;
    e = 4'hF;
    wd = 16'hFFFF;
    pulse(wr);
    slp = 1'b1;
    pulse(tick);
    note(4'h7, 16'h000F);
    note(4'h8, 16'h0001);
    c.clock_source_select = 2'h0;
    pulse(tick);
    cyc(1);
    note(4'h0, 16'h0000);
    slp = 1'b0;
    stop_test;
  end
endmodule
`default_nettype wire
